// ### hw/cdr_pkg.sv
// Shared constants and carrier types of the cable diagnostic result registers
package cdr_pkg;

    // Register offsets, normal space
    localparam logic [15:0] ADDR_PEAK_AMP_D_HI   = 16'h01a3;
    localparam logic [15:0] ADDR_GENERAL_FLAGS   = 16'h01a4;
    localparam logic [15:0] ADDR_SIGN_PAIR_AB    = 16'h01a5;
    localparam logic [15:0] ADDR_SIGN_PAIR_CD    = 16'h01a6;
    localparam logic [15:0] ADDR_GAIN_POL_CFG    = 16'h01d5;
    // Register offset inside the coding sublayer space
    localparam logic [15:0] ADDR_PCS_CONTROL     = 16'h0000;

    // Field positions
    localparam int AMP_LO_LSB          = 0;
    localparam int AMP_HI_LSB          = 8;
    localparam int CROSS_LSB           = 8;
    localparam int OVERFLOW_LSB        = 4;
    localparam int SIGN_SECOND_LSB     = 5;
    localparam int CFG_COMPLIANCE_BIT  = 3;
    localparam int CFG_TX_INVERT_BIT   = 1;
    localparam int CFG_RX_INVERT_BIT   = 0;
    localparam int CODING_SUBLAYER_RESET_BIT       = 5;

    // Reset values
    localparam logic [15:0] CFG_RESET_VALUE    = 16'hf500;
    localparam logic [15:0] RESULT_RESET_VALUE = 16'h0000;
    localparam logic [15:0] READ_ZERO          = 16'h0000;

    // Results delivered by the reflectometry engine; four-bit groups are {D,C,B,A}
    typedef struct packed {
        logic [6:0] pair_d_fifth_peak_amplitude;
        logic [6:0] pair_d_fourth_peak_amplitude;
        logic [3:0] cross_flag;
        logic [3:0] peak_overflow;
        logic [4:0] sign_d;
        logic [4:0] sign_c;
        logic [4:0] sign_b;
        logic [4:0] sign_a;
    } cdr_result_t;

    localparam int RESULT_W = $bits(cdr_result_t);

    // One management access, valid for one cycle
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        coding_space;
        logic [15:0] addr;
        logic [15:0] wdata;
    } cdr_mgmt_req_t;

    // Coding sublayer reset sequence
    typedef enum logic [1:0] {
        CDR_SEQ_IDLE  = 2'b00,
        CDR_SEQ_CLEAR = 2'b01,
        CDR_SEQ_SOFT  = 2'b10
    } cdr_seq_state_t;

endpackage

// ### hw/cdr_hold_reg.sv
// Load-and-hold register for one diagnostic result set
`timescale 1ns/10ps
`default_nettype none
module cdr_hold_reg #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Load side
    input  wire logic         load,
    input  wire logic [W-1:0] d,
    // Held value
    output logic      [W-1:0] q
);

    // Take a new value only on load, otherwise hold
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else if (load) begin
            q <= d;
        end
    end

endmodule
`default_nettype wire

// ### hw/cdr_reset_seq.sv
// Self-clearing coding sublayer reset followed by a soft reset pulse
`timescale 1ns/10ps
`default_nettype none
module cdr_reset_seq (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Request from a register write
    input  wire logic start,
    // Bit as seen by software, and soft reset pulse
    output logic      reset_bit,
    output logic      soft_pulse
);

    cdr_pkg::cdr_seq_state_t state_reg;

    // Bit reads one for one cycle, then the soft reset fires for one cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg  <= cdr_pkg::CDR_SEQ_IDLE;
            reset_bit  <= 1'b0;
            soft_pulse <= 1'b0;
        end else begin
            case (state_reg)
                cdr_pkg::CDR_SEQ_IDLE: begin
                    soft_pulse <= 1'b0;
                    if (start) begin
                        state_reg <= cdr_pkg::CDR_SEQ_CLEAR;
                        reset_bit <= 1'b1;
                    end
                end
                cdr_pkg::CDR_SEQ_CLEAR: begin
                    state_reg  <= cdr_pkg::CDR_SEQ_SOFT;
                    reset_bit  <= 1'b0;
                    soft_pulse <= 1'b1;
                end
                default: begin
                    state_reg  <= cdr_pkg::CDR_SEQ_IDLE;
                    reset_bit  <= 1'b0;
                    soft_pulse <= 1'b0;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ### hw/cdr_result_regs.sv
// Cable diagnostic result, configuration and coding sublayer control registers
// Function
// - Pair D fourth and fifth peak amplitudes read as 7-bit fields, low/high byte.
// - Cross reflection flags for D, C, B, A read in bits 11 to 8.
// - Peak overflow flags for D, C, B, A read in bits 7 to 4.
// - Peak signs of pair A in bits 4:0, pair B in 9:5.
// - Peak signs of pair C in bits 4:0, pair D in 9:5.
// - Config bit 3 with forced speed selects the compliance swing level.
// - Config bit 1 inverts the serial MAC-side transmit pair.
// - Config bit 0 inverts the serial MAC-side receive pair.
// - Writing one to control bit 5 resets that register set, then self-clears.
// - A coding sublayer reset is followed by a soft reset that restores the configuration register only; results are kept.
// - Control bits 4 to 0 ignore writes and read as zero.
`timescale 1ns/10ps
`default_nettype none
module cdr_result_regs (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // Management register port
    input  wire cdr_pkg::cdr_mgmt_req_t mgmt_req,
    output logic                 [15:0] rd_data,
    output logic                        rd_valid,
    // Reflectometry engine results
    input  wire logic                   run_done,
    input  wire cdr_pkg::cdr_result_t   result_in,
    // Link state
    input  wire logic                   speed_forced,
    // Controls toward the analog and serial blocks
    output logic                        compliance_swing_select,
    output logic                        serial_tx_pair_invert,
    output logic                        serial_rx_pair_invert,
    output logic                        soft_reset_req
);

    cdr_pkg::cdr_result_t res_q;
    logic [15:0]          cfg_reg;
    logic [15:0]          rd_data_next;
    logic                 pcs_bit;
    logic                 soft_pulse;
    logic                 wr_cfg;
    logic                 wr_pcs;
    logic                 rd_pcs;

    // Access decode; the control register lives only in the indirect space
    // configuration write in the normal space only, control access in the indirect space only
    assign wr_cfg = mgmt_req.wr && !mgmt_req.coding_space
                    && (mgmt_req.addr == cdr_pkg::ADDR_GAIN_POL_CFG);
    assign wr_pcs = mgmt_req.wr && mgmt_req.coding_space
                    && (mgmt_req.addr == cdr_pkg::ADDR_PCS_CONTROL);
    assign rd_pcs = mgmt_req.coding_space && (mgmt_req.addr == cdr_pkg::ADDR_PCS_CONTROL);

    // Result capture
    // atomic result update
    cdr_hold_reg #(
        .W (cdr_pkg::RESULT_W)
    ) u_results (
        .clk   (clk),
        .rst_n (rst_n),
        .load  (run_done),
        .d     (result_in),
        .q     (res_q)
    );

    // Coding sublayer reset sequence
    // self-clearing reset bit
    cdr_reset_seq u_pcs_seq (
        .clk        (clk),
        .rst_n      (rst_n),
        .start      (wr_pcs && mgmt_req.wdata[cdr_pkg::CODING_SUBLAYER_RESET_BIT]),
        .reset_bit  (pcs_bit),
        .soft_pulse (soft_pulse)
    );

    // Configuration register, restored to defaults by a soft reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg <= cdr_pkg::CFG_RESET_VALUE;
        end else if (soft_pulse) begin
            cfg_reg <= cdr_pkg::CFG_RESET_VALUE;
        end else if (wr_cfg) begin
            cfg_reg <= mgmt_req.wdata;
        end
    end

    // Polarity controls come straight from the configuration flops
    // transmit pair invert
    assign serial_tx_pair_invert = cfg_reg[cdr_pkg::CFG_TX_INVERT_BIT];
    assign serial_rx_pair_invert = cfg_reg[cdr_pkg::CFG_RX_INVERT_BIT];
    assign soft_reset_req        = soft_pulse;

    // Compliance swing only applies when the speed is forced
    // compliance swing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            compliance_swing_select <= 1'b0;
        end else begin
            compliance_swing_select <= cfg_reg[cdr_pkg::CFG_COMPLIANCE_BIT] && speed_forced;
        end
    end

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        rd_data_next = cdr_pkg::READ_ZERO;
        if (rd_pcs) begin
            rd_data_next[cdr_pkg::CODING_SUBLAYER_RESET_BIT] = pcs_bit;
        end else if (mgmt_req.coding_space) begin
            rd_data_next = cdr_pkg::READ_ZERO;
        end else if (mgmt_req.addr == cdr_pkg::ADDR_PEAK_AMP_D_HI) begin
            rd_data_next[cdr_pkg::AMP_LO_LSB +: 7] = res_q.pair_d_fourth_peak_amplitude;
            rd_data_next[cdr_pkg::AMP_HI_LSB +: 7] = res_q.pair_d_fifth_peak_amplitude;
        end else if (mgmt_req.addr == cdr_pkg::ADDR_GENERAL_FLAGS) begin
            rd_data_next[cdr_pkg::CROSS_LSB +: 4]    = res_q.cross_flag;
            rd_data_next[cdr_pkg::OVERFLOW_LSB +: 4] = res_q.peak_overflow;
        end else if (mgmt_req.addr == cdr_pkg::ADDR_SIGN_PAIR_AB) begin
            rd_data_next[0 +: 5]                        = res_q.sign_a;
            rd_data_next[cdr_pkg::SIGN_SECOND_LSB +: 5] = res_q.sign_b;
        end else if (mgmt_req.addr == cdr_pkg::ADDR_SIGN_PAIR_CD) begin
            rd_data_next[0 +: 5]                        = res_q.sign_c;
            rd_data_next[cdr_pkg::SIGN_SECOND_LSB +: 5] = res_q.sign_d;
        end else if (mgmt_req.addr == cdr_pkg::ADDR_GAIN_POL_CFG) begin
            rd_data_next = cfg_reg;
        end
    end

    // Read answer one cycle after the request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data  <= cdr_pkg::READ_ZERO;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= mgmt_req.rd;
            if (mgmt_req.rd) begin
                rd_data <= rd_data_next;
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_result_hold_stable: assert property (
        !run_done |=> $stable(res_q))
        else $error("results changed without a completed run");

    a_amp_read_map: assert property (
        (mgmt_req.rd && !mgmt_req.coding_space && !run_done
         && mgmt_req.addr == cdr_pkg::ADDR_PEAK_AMP_D_HI)
        |=> rd_valid && rd_data == {1'b0, res_q.pair_d_fifth_peak_amplitude,
                                    1'b0, res_q.pair_d_fourth_peak_amplitude})
        else $error("amplitude read mismatch");

    a_flag_read_map: assert property (
        (mgmt_req.rd && !mgmt_req.coding_space && !run_done
         && mgmt_req.addr == cdr_pkg::ADDR_GENERAL_FLAGS)
        |=> rd_data == {4'h0, res_q.cross_flag, res_q.peak_overflow, 4'h0})
        else $error("general flags read mismatch");

    a_sign_ab_map: assert property (
        (mgmt_req.rd && !mgmt_req.coding_space && !run_done
         && mgmt_req.addr == cdr_pkg::ADDR_SIGN_PAIR_AB)
        |=> rd_data == {6'h00, res_q.sign_b, res_q.sign_a})
        else $error("pair A/B sign read mismatch");

    a_sign_cd_map: assert property (
        (mgmt_req.rd && !mgmt_req.coding_space && !run_done
         && mgmt_req.addr == cdr_pkg::ADDR_SIGN_PAIR_CD)
        |=> rd_data == {6'h00, res_q.sign_d, res_q.sign_c})
        else $error("pair C/D sign read mismatch");

    a_swing_needs_force: assert property (
        compliance_swing_select |-> $past(speed_forced)
                                    && $past(cfg_reg[cdr_pkg::CFG_COMPLIANCE_BIT]))
        else $error("compliance swing without forced speed");

    a_tx_invert_write: assert property (
        (wr_cfg && !soft_pulse) |=> serial_tx_pair_invert == $past(mgmt_req.wdata[1]))
        else $error("transmit invert did not follow write");

    a_rx_invert_write: assert property (
        (wr_cfg && !soft_pulse) |=> serial_rx_pair_invert == $past(mgmt_req.wdata[0]))
        else $error("receive invert did not follow write");

    a_pcs_self_clear: assert property (
        pcs_bit |=> !pcs_bit)
        else $error("reset bit did not clear itself");

    a_soft_follows: assert property (
        (wr_pcs && mgmt_req.wdata[cdr_pkg::CODING_SUBLAYER_RESET_BIT] && !pcs_bit && !soft_pulse)
        |=> pcs_bit ##1 soft_reset_req ##1 (cfg_reg == cdr_pkg::CFG_RESET_VALUE))
        else $error("soft reset did not follow reset bit");

    a_pcs_low_zero: assert property (
        (mgmt_req.rd && rd_pcs) |=> rd_data[4:0] == 5'h00)
        else $error("reserved control bits read nonzero");

    // Read answer timing and read data hold
    a_rd_valid_pulse: assert property (
        mgmt_req.rd |=> rd_valid)
        else $error("read answer missing");

    a_rd_valid_quiet: assert property (
        !mgmt_req.rd |=> !rd_valid)
        else $error("read answer without a request");

    a_rd_data_hold: assert property (
        !mgmt_req.rd |=> $stable(rd_data))
        else $error("read data changed without a read");

    // Reserved result bits always read zero
    a_amp_reserved_zero: assert property (
        (mgmt_req.rd && !mgmt_req.coding_space
         && mgmt_req.addr == cdr_pkg::ADDR_PEAK_AMP_D_HI)
        |=> !rd_data[15] && !rd_data[7])
        else $error("amplitude reserved bits nonzero");

    a_flag_reserved_zero: assert property (
        (mgmt_req.rd && !mgmt_req.coding_space
         && mgmt_req.addr == cdr_pkg::ADDR_GENERAL_FLAGS)
        |=> rd_data[15:12] == 4'h0 && rd_data[3:0] == 4'h0)
        else $error("general flags reserved bits nonzero");

    a_sign_reserved_zero: assert property (
        (mgmt_req.rd && !mgmt_req.coding_space
         && (mgmt_req.addr == cdr_pkg::ADDR_SIGN_PAIR_AB
             || mgmt_req.addr == cdr_pkg::ADDR_SIGN_PAIR_CD))
        |=> rd_data[15:10] == 6'h00)
        else $error("sign reserved bits nonzero");

    // Result capture takes the engine word as delivered
    a_result_load: assert property (
        run_done |=> res_q == $past(result_in))
        else $error("results not taken on a completed run");

    // Configuration storage, read back and soft reset restore
    a_cfg_read_back: assert property (
        (mgmt_req.rd && !mgmt_req.coding_space
         && mgmt_req.addr == cdr_pkg::ADDR_GAIN_POL_CFG)
        |=> rd_data == $past(cfg_reg))
        else $error("configuration read mismatch");

    a_cfg_write_store: assert property (
        (wr_cfg && !soft_pulse) |=> cfg_reg == $past(mgmt_req.wdata))
        else $error("configuration write not stored");

    a_cfg_soft_restore: assert property (
        soft_pulse |=> cfg_reg == cdr_pkg::CFG_RESET_VALUE)
        else $error("soft reset did not restore configuration");

    // Reset bit and soft reset pulse ordering
    a_soft_single: assert property (
        soft_reset_req |=> !soft_reset_req)
        else $error("soft reset pulse longer than one cycle");

    a_soft_after_bit: assert property (
        soft_reset_req |-> $past(pcs_bit))
        else $error("soft reset without a preceding reset bit");

    a_pcs_bit_cause: assert property (
        $rose(pcs_bit)
        |-> $past(wr_pcs && mgmt_req.wdata[cdr_pkg::CODING_SUBLAYER_RESET_BIT]))
        else $error("reset bit set without a write of one");

    // Compliance swing follows the configuration and the forced speed
    a_swing_follows: assert property (
        (cfg_reg[cdr_pkg::CFG_COMPLIANCE_BIT] && speed_forced) |=> compliance_swing_select)
        else $error("compliance swing not selected");

    a_swing_normal: assert property (
        !cfg_reg[cdr_pkg::CFG_COMPLIANCE_BIT] |=> !compliance_swing_select)
        else $error("compliance swing selected while option clear");

    // Address decode: the control register only answers in the indirect space
    a_direct_zero_read: assert property (
        (mgmt_req.rd && !mgmt_req.coding_space
         && mgmt_req.addr == cdr_pkg::ADDR_PCS_CONTROL)
        |=> rd_data == cdr_pkg::READ_ZERO)
        else $error("direct address zero read nonzero");

    a_coding_other_zero: assert property (
        (mgmt_req.rd && mgmt_req.coding_space
         && mgmt_req.addr != cdr_pkg::ADDR_PCS_CONTROL)
        |=> rd_data == cdr_pkg::READ_ZERO)
        else $error("unmapped indirect address read nonzero");

    a_unmapped_zero: assert property (
        (mgmt_req.rd && !mgmt_req.coding_space
         && mgmt_req.addr != cdr_pkg::ADDR_PEAK_AMP_D_HI
         && mgmt_req.addr != cdr_pkg::ADDR_GENERAL_FLAGS
         && mgmt_req.addr != cdr_pkg::ADDR_SIGN_PAIR_AB
         && mgmt_req.addr != cdr_pkg::ADDR_SIGN_PAIR_CD
         && mgmt_req.addr != cdr_pkg::ADDR_GAIN_POL_CFG)
        |=> rd_data == cdr_pkg::READ_ZERO)
        else $error("unmapped address read nonzero");

    // Main scenarios
    c_run_then_read: cover property (run_done ##1 mgmt_req.rd);
    c_coding_sublayer_reset_seq: cover property (wr_pcs ##1 pcs_bit ##1 soft_reset_req);
    c_swing_on:      cover property (compliance_swing_select);
    c_both_invert:   cover property (serial_tx_pair_invert && serial_rx_pair_invert);
    c_ovf_loaded:    cover property (run_done && (result_in.peak_overflow != 4'h0));

endmodule
`default_nettype wire

// ### testbench/cdr_tb.sv
// Self-checking bench for the cable diagnostic result registers
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic                   clk;
    logic                   rst_n;
    cdr_pkg::cdr_mgmt_req_t mgmt_req;
    logic            [15:0] rd_data;
    logic                   rd_valid;
    logic                   run_done;
    cdr_pkg::cdr_result_t   result_in;
    logic                   speed_forced;
    logic                   comp_sel;
    logic                   tx_inv;
    logic                   rx_inv;
    logic                   soft_reset_req;
    int                     err_count;
    int                     checked;
    int                     cycles;
    cdr_pkg::cdr_result_t   set_a;
    cdr_pkg::cdr_result_t   set_b;

    cdr_result_regs u_dut (
        .clk(clk), .rst_n(rst_n), .mgmt_req(mgmt_req), .rd_data(rd_data),
        .rd_valid(rd_valid), .run_done(run_done), .result_in(result_in),
        .speed_forced(speed_forced), .compliance_swing_select(comp_sel),
        .serial_tx_pair_invert(tx_inv), .serial_rx_pair_invert(rx_inv),
        .soft_reset_req(soft_reset_req)
    );

    // Free-running 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk1(input string name, input logic exp, input logic got);
        chk16(name, {15'h0000, exp}, {15'h0000, got});
    endtask

    // One write after one idle edge; returns just after the taking edge
    task automatic reg_wr(input logic cs, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        #1 mgmt_req = '{wr: 1'b1, rd: 1'b0, coding_space: cs, addr: a, wdata: d};
        @(posedge clk);
        #1 mgmt_req.wr = 1'b0;
    endtask

    // One read, answer judged in the cycle it stands
    task automatic reg_rd(input string name, input logic cs, input logic [15:0] a,
                          input logic [15:0] exp);
        @(posedge clk);
        #1 mgmt_req = '{wr: 1'b0, rd: 1'b1, coding_space: cs, addr: a, wdata: 16'h0000};
        @(posedge clk);
        #1 mgmt_req.rd = 1'b0;
        chk1("rd_valid", 1'b1, rd_valid);
        chk16(name, exp, rd_data);
    endtask

    // Reads all four result registers against one result set
    task automatic check_set(input cdr_pkg::cdr_result_t r);
        reg_rd("amp_d_hi", 1'b0, cdr_pkg::ADDR_PEAK_AMP_D_HI,
               {1'b0, r.pair_d_fifth_peak_amplitude, 1'b0, r.pair_d_fourth_peak_amplitude});
        reg_rd("flags", 1'b0, cdr_pkg::ADDR_GENERAL_FLAGS,
               {4'h0, r.cross_flag, r.peak_overflow, 4'h0});
        reg_rd("sign_ab", 1'b0, cdr_pkg::ADDR_SIGN_PAIR_AB, {6'h00, r.sign_b, r.sign_a});
        reg_rd("sign_cd", 1'b0, cdr_pkg::ADDR_SIGN_PAIR_CD, {6'h00, r.sign_d, r.sign_c});
    endtask

    task automatic t_reset_values();
        chk1("tx_inv", 1'b0, tx_inv);
        chk1("rx_inv", 1'b0, rx_inv);
        chk1("comp_sel", 1'b0, comp_sel);
        check_set('0);
        reg_rd("cfg", 1'b0, cdr_pkg::ADDR_GAIN_POL_CFG, 16'hf500);
        reg_rd("pcs", 1'b1, cdr_pkg::ADDR_PCS_CONTROL, 16'h0000);
        reg_rd("direct 0", 1'b0, 16'h0000, 16'h0000);
        reg_rd("coding other", 1'b1, cdr_pkg::ADDR_GENERAL_FLAGS, 16'h0000);
        reg_rd("unmapped", 1'b0, 16'h01a7, 16'h0000);
    endtask

    // Load, same-cycle read sees old set, hold, read-only writes ignored
    task automatic t_results();
        @(posedge clk);
        #1 result_in = set_a;
        run_done = 1'b1;
        mgmt_req = '{wr: 1'b0, rd: 1'b1, coding_space: 1'b0,
                     addr: cdr_pkg::ADDR_GENERAL_FLAGS, wdata: 16'h0000};
        @(posedge clk);
        #1 mgmt_req.rd = 1'b0;
        run_done = 1'b0;
        result_in = set_b;
        chk16("flags old", 16'h0000, rd_data);
        check_set(set_a);
        reg_wr(1'b0, cdr_pkg::ADDR_GENERAL_FLAGS, 16'hffff);
        reg_wr(1'b0, cdr_pkg::ADDR_SIGN_PAIR_AB, 16'hffff);
        check_set(set_a);
        run_done = 1'b1;
        @(posedge clk);
        #1 run_done = 1'b0;
        result_in = set_a;
        check_set(set_b);
    endtask

    task automatic t_config();
        reg_wr(1'b0, cdr_pkg::ADDR_GAIN_POL_CFG, 16'h0002);
        chk1("tx_inv", 1'b1, tx_inv);
        chk1("rx_inv", 1'b0, rx_inv);
        reg_wr(1'b0, cdr_pkg::ADDR_GAIN_POL_CFG, 16'h0001);
        chk1("tx_inv", 1'b0, tx_inv);
        chk1("rx_inv", 1'b1, rx_inv);
        reg_wr(1'b0, cdr_pkg::ADDR_GAIN_POL_CFG, 16'h0008);
        repeat (2) @(posedge clk);
        #1 chk1("comp unforced", 1'b0, comp_sel);
        speed_forced = 1'b1;
        repeat (2) @(posedge clk);
        #1 chk1("comp forced", 1'b1, comp_sel);
        reg_wr(1'b0, cdr_pkg::ADDR_GAIN_POL_CFG, 16'habc7);
        repeat (2) @(posedge clk);
        #1 chk1("comp off", 1'b0, comp_sel);
        reg_wr(1'b0, cdr_pkg::ADDR_GAIN_POL_CFG, 16'habcf);
        reg_rd("cfg", 1'b0, cdr_pkg::ADDR_GAIN_POL_CFG, 16'habcf);
        chk1("tx_inv", 1'b1, tx_inv);
        speed_forced = 1'b0;
        repeat (2) @(posedge clk);
        #1 chk1("comp dropped", 1'b0, comp_sel);
    endtask

    // Coding sublayer reset: self-clear, one soft reset pulse, config defaults back
    task automatic t_coding_sublayer_reset();
        int n;
        n = 0;
        reg_wr(1'b1, cdr_pkg::ADDR_PCS_CONTROL, 16'h001f);
        reg_rd("pcs low bits", 1'b1, cdr_pkg::ADDR_PCS_CONTROL, 16'h0000);
        chk1("no soft reset", 1'b0, soft_reset_req);
        reg_wr(1'b1, cdr_pkg::ADDR_PCS_CONTROL, 16'h003f);
        while (soft_reset_req !== 1'b1 && n < 10) begin
            @(posedge clk);
            #1 n++;
        end
        chk1("soft pulse", 1'b1, soft_reset_req);
        @(posedge clk);
        #1 chk1("soft pulse end", 1'b0, soft_reset_req);
        chk1("tx_inv", 1'b0, tx_inv);
        chk1("rx_inv", 1'b0, rx_inv);
        reg_rd("pcs cleared", 1'b1, cdr_pkg::ADDR_PCS_CONTROL, 16'h0000);
        reg_rd("cfg default", 1'b0, cdr_pkg::ADDR_GAIN_POL_CFG, 16'hf500);
        check_set(set_b);
    endtask

    // Main sequence
    initial begin
        err_count = 0;
        checked = 0;
        cycles = 0;
        rst_n = 1'b0;
        mgmt_req = '0;
        run_done = 1'b0;
        result_in = '0;
        speed_forced = 1'b0;
        set_a = '{7'h55, 7'h2a, 4'b1010, 4'b0101, 5'h15, 5'h0a, 5'h10, 5'h01};
        set_b = '1;
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        t_reset_values();
        t_results();
        t_config();
        t_coding_sublayer_reset();
        conclude();
    end
endmodule
`default_nettype wire
